//--- rtl/xoc_consts.vh
// Offsets, field positions, reset values and timing counts for the oscillator control block.
`ifndef XOC_CONSTS_VH
`define XOC_CONSTS_VH
`define XOC_ADDR_MAIN_CTRL 4'h0
`define XOC_ADDR_SLOW_CTRL 4'h1
`define XOC_ADDR_STATUS 4'h2
`define XOC_ADDR_IRQ_FLAG 4'h3
`define XOC_ADDR_IRQ_EN 4'h4
`define XOC_MAIN_ENABLE 1
`define XOC_MAIN_RUN_STDBY 6
`define XOC_MAIN_ON_REQ 7
`define XOC_MAIN_STARTUP_LO 12
`define XOC_MAIN_STARTUP_HI 15
`define XOC_SLOW_ENABLE 1
`define XOC_SLOW_XTAL 2
`define XOC_MAIN_CTRL_RST 32'h00000000
`define XOC_SLOW_CTRL_RST 32'h00000000
`define XOC_BIT_MAIN_RDY 0
`define XOC_BIT_SLOW_RUN 1
`define XOC_SLEEP_ACTIVE 2'h0
`define XOC_SLEEP_IDLE 2'h1
`define XOC_SLEEP_STDBY 2'h2
`define XOC_STARTUP_BASE_CYC 16'h0001
`endif

//--- rtl/xoc_ctrl.v
// Control logic for the main and 32 kHz crystal oscillators with registers and interrupt.
//
// Implementation choices: the strobed register port and the address map.
`include "xoc_consts.vh"

// Notes on behaviour
// - Enabled, no on-request, no standby-run: runs in idle, stops in standby; disabled stays off.
// - On-request without standby-run: idle runs only on peripheral request; standby stops.
// - Standby-run without on-request: runs continuously in idle and standby.
// - Both set: runs in idle or standby only on peripheral request.
// - After reset or restart from off, apply start-up delay chosen by start-up field.
// - Clock output stays gated off for the whole start-up delay.
// - Ready flag sets once the selected start-up delay has elapsed.
// - Interrupt on ready rising edge, only when its enable bit is set.
// - Slow oscillator supports external clock input or crystal between its pins.
// - At reset the slow oscillator is off and both pins are free.
// - Crystal mode takes over both slow oscillator pins.
// - External clock mode takes over only the input pin.
// - Enable bit starts slow oscillator; crystal select picks crystal when one.
module xoc_ctrl (
	input wire clk,
	input wire rst,
	input wire [3:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [1:0] sleep_mode,
	input wire periph_req,
	input wire main_osc_clk_raw,
	output reg main_osc_run,
	output reg main_osc_gate,
	output reg slow_osc_run,
	output reg slow_osc_in_pin_own,
	output reg slow_osc_out_pin_own,
	output reg slow_osc_drive,
	output reg irq
);

	// Registers written by software, then start-up state and input synchronisers.
	reg [31:0] main_ctrl;
	reg [31:0] slow_ctrl;
	reg [1:0] irq_en;
	reg [1:0] irq_flag;
	reg main_osc_ready;
	reg [20:0] startup_cnt;
	reg run_d;
	reg [1:0] sleep_s1;
	reg [1:0] sleep_s2;
	reg req_s1;
	reg req_s2;
	reg osc_s1;
	reg osc_s2;

	wire main_enable = main_ctrl[`XOC_MAIN_ENABLE];
	wire run_stdby = main_ctrl[`XOC_MAIN_RUN_STDBY];
	wire on_req = main_ctrl[`XOC_MAIN_ON_REQ];
	wire [3:0] startup_sel = main_ctrl[`XOC_MAIN_STARTUP_HI:`XOC_MAIN_STARTUP_LO];
	wire slow_en = slow_ctrl[`XOC_SLOW_ENABLE];
	wire slow_xtal = slow_ctrl[`XOC_SLOW_XTAL];
	reg next_run;
	wire [20:0] startup_len;
	wire ready_rise;
	wire slow_rise;
	reg [1:0] next_flag;

	// Start-up length doubles per step of the selection field, from one base count.
	assign startup_len = {5'h00, `XOC_STARTUP_BASE_CYC} << startup_sel;

	// Sleep behaviour table; active mode always runs when enabled.
	always @* begin
		next_run = 1'b0;
		if (main_enable) begin
			case (sleep_s2)
				`XOC_SLEEP_ACTIVE: next_run = 1'b1;
				`XOC_SLEEP_IDLE: next_run = on_req ? req_s2 : 1'b1;
				`XOC_SLEEP_STDBY: next_run = run_stdby & (on_req ? req_s2 : 1'b1);
				default: next_run = 1'b0;
			endcase
		end
	end

	assign ready_rise = next_run & run_d & (startup_cnt == startup_len) & ~main_osc_ready;
	assign slow_rise = slow_en & ~slow_osc_run;

	// Sleep state and request arrive from other logic, so they are synchronised first.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_s1 <= 2'h0;
			sleep_s2 <= 2'h0;
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
		end else begin
			sleep_s1 <= sleep_mode;
			sleep_s2 <= sleep_s1;
			req_s1 <= periph_req;
			req_s2 <= req_s1;
			osc_s1 <= main_osc_clk_raw;
			osc_s2 <= osc_s1;
		end
	end

	// Start-up counter restarts whenever the oscillator is off; ready follows it.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			run_d <= 1'b0;
			startup_cnt <= 21'h000000;
			main_osc_ready <= 1'b0;
			main_osc_run <= 1'b0;
			main_osc_gate <= 1'b0;
		end else begin
			run_d <= next_run;
			main_osc_run <= next_run;
			if (!next_run) begin
				startup_cnt <= 21'h000000;
				main_osc_ready <= 1'b0;
			end else if (startup_cnt != startup_len) begin
				startup_cnt <= startup_cnt + 21'h000001;
			end else begin
				main_osc_ready <= 1'b1;
			end
			// The gate opens only with ready, so unstable cycles never pass.
			main_osc_gate <= next_run & (ready_rise | main_osc_ready);
		end
	end

	// Slow oscillator pin ownership follows enable and crystal select.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_osc_run <= 1'b0;
			slow_osc_in_pin_own <= 1'b0;
			slow_osc_out_pin_own <= 1'b0;
			slow_osc_drive <= 1'b0;
		end else begin
			slow_osc_run <= slow_en;
			slow_osc_in_pin_own <= slow_en;
			slow_osc_out_pin_own <= slow_en & slow_xtal;
			slow_osc_drive <= slow_en & slow_xtal;
		end
	end

	// Status events are sticky; a new event beats a write-one clear in the same cycle.
	always @* begin
		next_flag = irq_flag;
		if (wr && addr == `XOC_ADDR_IRQ_FLAG)
			next_flag = next_flag & ~wdata[1:0];
		if (ready_rise)
			next_flag[`XOC_BIT_MAIN_RDY] = 1'b1;
		if (slow_rise)
			next_flag[`XOC_BIT_SLOW_RUN] = 1'b1;
	end

	// Register writes. Disabling the slow oscillator relies on software keeping other bits.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			main_ctrl <= `XOC_MAIN_CTRL_RST;
			slow_ctrl <= `XOC_SLOW_CTRL_RST;
			irq_en <= 2'h0;
			irq_flag <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_flag <= next_flag;
			irq <= |(next_flag & irq_en);
			if (wr) begin
				case (addr)
					`XOC_ADDR_MAIN_CTRL: main_ctrl <= wdata;
					`XOC_ADDR_SLOW_CTRL: slow_ctrl <= wdata;
					`XOC_ADDR_IRQ_EN: irq_en <= wdata[1:0];
					default: irq_en <= irq_en;
				endcase
			end
		end
	end

	// Read data stand one cycle after the strobe and read zero otherwise.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				`XOC_ADDR_MAIN_CTRL: rdata <= main_ctrl;
				`XOC_ADDR_SLOW_CTRL: rdata <= slow_ctrl;
				`XOC_ADDR_STATUS: rdata <= {29'h00000000, osc_s2, slow_osc_run, main_osc_ready};
				`XOC_ADDR_IRQ_FLAG: rdata <= {30'h00000000, irq_flag};
				`XOC_ADDR_IRQ_EN: rdata <= {30'h00000000, irq_en};
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

endmodule // xoc_ctrl

//--- tb/xoc_ctrl_sva.sv
// Port checker for the oscillator control block.
module xoc_ctrl_sva (
	input wire clk,
	input wire rst,
	input wire [3:0] addr,
	input wire rd,
	input wire [31:0] rdata,
	input wire main_osc_run,
	input wire main_osc_gate,
	input wire slow_osc_run,
	input wire slow_osc_in_pin_own,
	input wire slow_osc_out_pin_own,
	input wire slow_osc_drive,
	input wire irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	gate_needs_run_a: assert property (main_osc_gate |-> main_osc_run) else $error("gate");
	rise_masked_a: assert property ($rose(main_osc_run) |-> !main_osc_gate) else $error("mask");
	open_late_a: assert property ($rose(main_osc_gate) |-> $past(main_osc_run)) else $error("late");
	out_xtal_a: assert property (slow_osc_out_pin_own |-> slow_osc_drive) else $error("out");
	drive_own_a: assert property (slow_osc_drive |-> slow_osc_out_pin_own) else $error("drv");
	in_run_a: assert property (slow_osc_run |-> slow_osc_in_pin_own) else $error("in");
	own_run_a: assert property (slow_osc_in_pin_own |-> slow_osc_run) else $error("own");
	rd_ready_a: assert property (rd && addr == 4'h2 |=> rdata[0] == $past(main_osc_gate))
		else $error("rdy");
	cover property ($rose(main_osc_gate));
	cover property ($rose(irq));
	cover property (slow_osc_drive);
endmodule // xoc_ctrl_sva
bind xoc_ctrl xoc_ctrl_sva xoc_ctrl_sva_i (.*);

//--- tb/xoc_osc_model.sv
// Crystal stand-in for the oscillator control block.
module xoc_osc_model (
	input wire clk,
	input wire main_osc_run,
	output logic main_osc_clk_raw = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// A powered crystal swings each cycle; an unpowered one sits low.
	always @(negedge clk) begin
		main_osc_clk_raw <= main_osc_run ? !main_osc_clk_raw : 1'b0;
	end
endmodule // xoc_osc_model

//--- tb/crystal_oscillator_control_tb_top.sv
// Self-checking bench for the oscillator control block.
module crystal_oscillator_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, wr = 0, rd = 0, periph_req = 0, rd_d = 0;
	logic [3:0] addr = 4'h0;
	logic [1:0] sleep_mode = 2'h0;
	logic [31:0] wdata = 32'h0, rdata, r = 32'h7875;
	logic [63:0] h;
	logic [63:0] q[$];
	logic main_osc_clk_raw, main_osc_run, main_osc_gate, slow_osc_run, irq;
	logic slow_osc_in_pin_own, slow_osc_out_pin_own, slow_osc_drive;
	int fails = 0, checks_done = 0, n;
	always #25 clk = ~clk;
	xoc_osc_model xoc_osc_model_i (.*);
	xoc_ctrl xoc_ctrl_i (.*);
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	// The expected word and its mask wait in the queue until the data appear.
	task automatic rdr(input logic [3:0] a, input logic [31:0] m, e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		q.push_back({m, e});
		@(posedge clk);
		rd <= 0;
	endtask
	// Xorshift step that feeds random write data into the block.
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe.
	always @(posedge clk) begin
		if (rd_d) begin
			h = q.pop_front();
			chk(rdata & h[63:32], h[31:0], "rdata");
		end
		rd_d <= rd;
	end
	// The sequence needs under two thousand cycles.
	initial begin
		#1000000;
		fails++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		#1;
		chk({slow_osc_in_pin_own, slow_osc_out_pin_own, slow_osc_run}, 0, "pins");
		rdr(4'h1, 32'hFFFFFFFF, 0);
		rdr(4'hF, 32'hFFFFFFFF, 0);
		for (int x = 0; x < 2; x++) begin
			wrr(4'h1, 32'h2 | (x << 2));
			settle();
			chk({slow_osc_in_pin_own, slow_osc_out_pin_own, slow_osc_drive, slow_osc_run},
				{1'b1, x[0], x[0], 1'b1}, "own");
			wrr(4'h1, x << 2);
			settle();
			chk({slow_osc_in_pin_own, slow_osc_out_pin_own, slow_osc_run}, 0, "free");
		end
		r = xs(r);
		wrr(4'h3, 32'h3);
		wrr(4'h0, {r[1:0], 12'h002});
		n = 0;
		while (main_osc_gate !== 1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n >= (1 << r[1:0]) && n <= (1 << r[1:0]) + 4, 1, "startup");
		rdr(4'h2, 32'h3, 32'h1);
		chk(irq, 0, "masked");
		rdr(4'h3, 32'h3, 32'h1);
		wrr(4'h4, 32'h1);
		rdr(4'h4, 32'h3, 32'h1);
		settle();
		chk(irq, 1, "irq");
		wrr(4'h3, 32'h1);
		settle();
		chk(irq, 0, "cleared");
		// Each standby-run and on-request pairing in both sleep depths, request low and high.
		for (int c = 0; c < 16; c++) begin
			wrr(4'h0, {c[0], c[1], 6'h02});
			repeat (8) @(posedge clk);
			sleep_mode <= c[2] ? 2'h2 : 2'h1;
			periph_req <= c[3];
			settle();
			repeat (4) @(posedge clk);
			chk(main_osc_run, c[2] && !c[1] ? 0 : (c[0] ? c[3] : 1), "run");
			@(posedge clk);
			sleep_mode <= 2'h0;
		end
		wrr(4'h0, 32'h0);
		settle();
		chk(main_osc_run, 0, "off");
		rdr(4'h2, 32'h7, 32'h0);
		settle();
		conclude();
	end
endmodule // crystal_oscillator_control_tb_top
